// ==== logic/nft_pkg.sv ====
// Package for the network formation table: register numbers, reset values,
// table sizes and the packed carriers shared by the table, the ID map and the top.
// Assumes register numbers are used as-is as 16-bit holding-register addresses.
package nft_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Holding-register numbers
    localparam logic [15:0] REG_FORCED_PARENT = 16'h18e0;
    localparam logic [15:0] REG_SLAVE_ID_START = 16'h1966;
    localparam logic [15:0] REG_SLAVE_ID_LIST = 16'h1968;
    localparam logic [15:0] REG_ADDRESS_COUNT = 16'h1b59;
    localparam logic [15:0] REG_DEVICE_ADDRESSES = 16'h1b5a;
    localparam logic [15:0] REG_ROUTE_COUNT = 16'h1c85;
    localparam logic [15:0] REG_ROUTE_ADDRESSES = 16'h1c86;
    localparam logic [15:0] REG_SLOT_COUNT = 16'h1db1;
    localparam logic [15:0] REG_SLOT_AVAILABILITY = 16'h1db2;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes, fields and reset values
    localparam int unsigned TABLE_DEPTH = 50;
    localparam logic [5:0] TABLE_DEPTH_C = 6'h32;
    localparam int unsigned SERIAL_ADDR_LSB = 0;
    localparam int unsigned ADDR_W = 16;
    localparam logic [15:0] SLAVE_ID_START_RST = 16'h000b;
    localparam logic [15:0] FORCED_PARENT_RST = 16'h0000;
    localparam logic [15:0] FORCED_PARENT_NONE = 16'h0000;
    localparam logic [15:0] SLOTS_ALL = 16'h0080;
    localparam logic [15:0] SLOTS_FEW = 16'h0004;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef logic [5:0] index_t;

    typedef struct packed {
        logic [15:0] dev_addr;
        logic [15:0] first_hop_address;
        logic [15:0] slot_availability;
    } entry_t;

    typedef struct packed {
        logic valid;
        entry_t entry;
    } join_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

endpackage

// ==== logic/nft_table_store.sv ====
// Formation table storage: three positionally matched columns and one count.
// Assumes at most one join report per cycle from the radio side.
`timescale 1ns/10ps
module nft_table_store (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Join reports
    input wire nft_pkg::join_t join_i,
    // Read ports
    input wire nft_pkg::index_t rd_idx_a_i,
    output nft_pkg::entry_t rd_entry_a_o,
    input wire nft_pkg::index_t rd_idx_b_i,
    output nft_pkg::entry_t rd_entry_b_o,
    // Status
    output nft_pkg::index_t count_o,
    output logic known_o,
    output logic full_o
);
    import nft_pkg::*;

    entry_t mem_q [TABLE_DEPTH];
    index_t count_q;
    logic [TABLE_DEPTH-1:0] match;
    index_t match_idx;

    ////////////////////////////////////////////////////////////////////////////
    // Lookup of a reporting device among live entries
    for (genvar g = 0; g < TABLE_DEPTH; g++) begin : g_match
        assign match[g] = (6'(g) < count_q) && (mem_q[g].dev_addr == join_i.entry.dev_addr);
    end

    always_comb begin
        match_idx = '0;
        for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
            if (match[i]) begin
                match_idx = 6'(i);
            end
        end
    end

    assign known_o = |match;
    assign full_o = (count_q == TABLE_DEPTH_C);
    assign count_o = count_q;
    assign rd_entry_a_o = mem_q[rd_idx_a_i];
    assign rd_entry_b_o = mem_q[rd_idx_b_i];

    ////////////////////////////////////////////////////////////////////////////
    // Known devices refresh in place; new ones append in join order
    always_ff @(posedge core_clk_i) begin
        if (join_i.valid && known_o) begin
            mem_q[match_idx] <= join_i.entry;
        end else if (join_i.valid && !full_o) begin
            mem_q[count_q] <= join_i.entry;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_q <= '0;
        end else if (join_i.valid && !known_o && !full_o) begin
            count_q <= count_q + 6'h01;
        end
    end

endmodule

// ==== logic/nft_id_map.sv ====
// Slave ID to list index translation against a programmable starting ID.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module nft_id_map (
    // Translation
    input wire logic [15:0] slave_id_i,
    input wire logic [15:0] start_id_i,
    output nft_pkg::index_t index_o,
    output logic hit_o
);
    import nft_pkg::*;

    logic [15:0] offset;

    assign offset = slave_id_i - start_id_i;
    assign hit_o = (slave_id_i >= start_id_i) && (offset < 16'(TABLE_DEPTH));
    assign index_o = offset[5:0];

endmodule

// ==== logic/network_formation_table.sv ====
// Network formation table register bank of a master or repeater radio.
// Assumes the holding-register port and radio-side reports are synchronous to CORE_CLK_I.
//
// Contract
// - Own address is serial number low half
// - Master keeps address, hop, slots per device
// - Repeater keeps same entries for children
// - Hop equal to address means direct link
// - Slots 128 means every slot usable
// - Slots 4 means four of 128 slots
// - Register 7001 reports address section count
// - Registers 7002-7051 hold device addresses
// - Register 7301 reports route section count
// - Registers 7302-7351 hold first-hop addresses
// - Register 7601 reports slot section count
// - Registers 7602-7651 hold slot availability
// - Register 6502 starting slave ID, resets 11
// - Registers 6504 onward map consecutive slave IDs
// - Forced parent lies in 1 to 65535
// - Writing zero removes forcing, binding kept
// - Removal starts autonomous path search
// - Forcing selects parent only, not binding
// - Reading 6368 returns last written parent
// - New devices appended in join order
`timescale 1ns/10ps
module network_formation_table (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // Identity and role
    input wire logic [31:0] SERIAL_I,
    input wire logic ROLE_REPEATER_I,
    input wire logic BOUND_I,
    // Radio-side join reports
    input wire nft_pkg::join_t JOIN_I,
    // Holding-register port
    input wire nft_pkg::reg_req_t REG_REQ_I,
    output logic [15:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    // Slave ID translation
    input wire logic MAP_REQ_I,
    input wire logic [15:0] MAP_SLAVE_ID_I,
    output logic MAP_VALID_O,
    output logic MAP_HIT_O,
    output nft_pkg::entry_t MAP_ENTRY_O,
    output logic MAP_DIRECT_O,
    output logic MAP_SLOTS_ALL_O,
    output logic MAP_SLOTS_FEW_O,
    // Routing control
    output logic [15:0] DEVICE_ADDR_O,
    output logic [15:0] FORCED_PARENT_O,
    output logic FORCED_ACTIVE_O,
    output logic PATH_SEARCH_O,
    output logic BOUND_O
);
    import nft_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base);
        in_window = (addr >= base) && ((addr - base) < 16'(TABLE_DEPTH));
    endfunction

    function automatic index_t window_index(input logic [15:0] addr, input logic [15:0] base);
        logic [15:0] diff;
        diff = addr - base;
        window_index = diff[5:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [15:0] slave_id_start_q;
    logic [15:0] forced_parent_q;
    logic [15:0] dev_addr_q;
    logic addr_caught_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic forced_active_q;
    logic path_search_q;
    logic bound_q;
    logic map_valid_q;
    logic map_hit_q;
    entry_t map_entry_q;
    logic map_direct_q;
    logic map_all_q;
    logic map_few_q;

    entry_t entry_a;
    entry_t entry_b;
    index_t count;
    logic known;
    logic full;
    index_t map_index;
    logic map_in_range;

    logic sel_forced;
    logic sel_start;
    logic sel_list;
    logic sel_addr_cnt;
    logic sel_addr;
    logic sel_route_cnt;
    logic sel_route;
    logic sel_slot_cnt;
    logic sel_slot;
    index_t idx_a;
    logic idx_live;
    logic [15:0] count_word;
    logic [15:0] rdata_d;
    logic wr_forced;
    logic wr_start;
    logic map_hit_d;
    logic removal;

    ////////////////////////////////////////////////////////////////////////////
    // Table and translation

    nft_table_store u_table (
        .core_clk_i(CORE_CLK_I),
        .arst_n_i(ARST_N_I),
        .join_i(JOIN_I),
        .rd_idx_a_i(idx_a),
        .rd_entry_a_o(entry_a),
        .rd_idx_b_i(map_index),
        .rd_entry_b_o(entry_b),
        .count_o(count),
        .known_o(known),
        .full_o(full)
    );

    nft_id_map u_id_map (
        .slave_id_i(MAP_SLAVE_ID_I),
        .start_id_i(slave_id_start_q),
        .index_o(map_index),
        .hit_o(map_in_range)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    assign sel_forced = (REG_REQ_I.addr == REG_FORCED_PARENT);
    assign sel_start = (REG_REQ_I.addr == REG_SLAVE_ID_START);
    assign sel_list = in_window(REG_REQ_I.addr, REG_SLAVE_ID_LIST) && !ROLE_REPEATER_I;
    assign sel_addr_cnt = (REG_REQ_I.addr == REG_ADDRESS_COUNT);
    assign sel_addr = in_window(REG_REQ_I.addr, REG_DEVICE_ADDRESSES);
    assign sel_route_cnt = (REG_REQ_I.addr == REG_ROUTE_COUNT);
    assign sel_route = in_window(REG_REQ_I.addr, REG_ROUTE_ADDRESSES);
    assign sel_slot_cnt = (REG_REQ_I.addr == REG_SLOT_COUNT);
    assign sel_slot = in_window(REG_REQ_I.addr, REG_SLOT_AVAILABILITY);

    // One shared read port: the windows never overlap
    assign idx_a = sel_list ? window_index(REG_REQ_I.addr, REG_SLAVE_ID_LIST) :
                   sel_addr ? window_index(REG_REQ_I.addr, REG_DEVICE_ADDRESSES) :
                   sel_route ? window_index(REG_REQ_I.addr, REG_ROUTE_ADDRESSES) :
                   window_index(REG_REQ_I.addr, REG_SLOT_AVAILABILITY);
    // Stale words past the count read as zero
    assign idx_live = (idx_a < count);
    assign count_word = {10'h000, count};

    assign rdata_d = sel_forced ? forced_parent_q :
                     sel_start ? slave_id_start_q :
                     sel_list ? (idx_live ? entry_a.dev_addr : 16'h0000) :
                     sel_addr_cnt ? count_word :
                     sel_addr ? (idx_live ? entry_a.dev_addr : 16'h0000) :
                     sel_route_cnt ? count_word :
                     sel_route ? (idx_live ? entry_a.first_hop_address : 16'h0000) :
                     sel_slot_cnt ? count_word :
                     sel_slot ? (idx_live ? entry_a.slot_availability : 16'h0000) :
                     16'h0000;

    assign wr_forced = REG_REQ_I.wr && sel_forced;
    assign wr_start = REG_REQ_I.wr && sel_start;
    // Zero is the removal code, so any nonzero value is a legal parent
    assign removal = wr_forced && (REG_REQ_I.wdata == FORCED_PARENT_NONE) && forced_active_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_REQ_I.rd;
            rdata_q <= REG_REQ_I.rd ? rdata_d : rdata_q;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            slave_id_start_q <= SLAVE_ID_START_RST;
        end else if (wr_start) begin
            slave_id_start_q <= REG_REQ_I.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Forced routing

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            forced_parent_q <= FORCED_PARENT_RST;
            forced_active_q <= 1'b0;
            path_search_q <= 1'b0;
        end else begin
            if (wr_forced) begin
                forced_parent_q <= REG_REQ_I.wdata;
                forced_active_q <= (REG_REQ_I.wdata != FORCED_PARENT_NONE);
            end
            path_search_q <= removal;
        end
    end

    // Binding is owned by the radio; forcing never alters it
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            bound_q <= 1'b0;
        end else begin
            bound_q <= BOUND_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Own device address, caught once after reset release

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            dev_addr_q <= '0;
            addr_caught_q <= 1'b0;
        end else if (!addr_caught_q) begin
            dev_addr_q <= SERIAL_I[SERIAL_ADDR_LSB +: ADDR_W];
            addr_caught_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Slave ID translation, master only

    assign map_hit_d = MAP_REQ_I && map_in_range && (map_index < count) && !ROLE_REPEATER_I;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            map_valid_q <= 1'b0;
            map_hit_q <= 1'b0;
            map_entry_q <= '0;
            map_direct_q <= 1'b0;
            map_all_q <= 1'b0;
            map_few_q <= 1'b0;
        end else begin
            map_valid_q <= MAP_REQ_I;
            map_hit_q <= map_hit_d;
            map_entry_q <= map_hit_d ? entry_b : '0;
            map_direct_q <= map_hit_d && (entry_b.first_hop_address == entry_b.dev_addr);
            map_all_q <= map_hit_d && (entry_b.slot_availability == SLOTS_ALL);
            map_few_q <= map_hit_d && (entry_b.slot_availability == SLOTS_FEW);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign REG_RDATA_O = rdata_q;
    assign REG_RVALID_O = rvalid_q;
    assign MAP_VALID_O = map_valid_q;
    assign MAP_HIT_O = map_hit_q;
    assign MAP_ENTRY_O = map_entry_q;
    assign MAP_DIRECT_O = map_direct_q;
    assign MAP_SLOTS_ALL_O = map_all_q;
    assign MAP_SLOTS_FEW_O = map_few_q;
    assign DEVICE_ADDR_O = dev_addr_q;
    assign FORCED_PARENT_O = forced_parent_q;
    assign FORCED_ACTIVE_O = forced_active_q;
    assign PATH_SEARCH_O = path_search_q;
    assign BOUND_O = bound_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_serial_addr: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        addr_caught_q |-> DEVICE_ADDR_O == $past(DEVICE_ADDR_O) || !$past(addr_caught_q))
        else $error("device address changed after capture");

    chk_append_order: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        JOIN_I.valid && !known && !full |=> count == $past(count) + 6'h01)
        else $error("new device not appended");

    chk_count_hold: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !JOIN_I.valid || known || full |=> count == $past(count))
        else $error("table count moved without a new device");

    chk_count_bound: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        count <= TABLE_DEPTH_C)
        else $error("table count above depth");

    chk_count_read: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        REG_REQ_I.rd && sel_addr_cnt && !JOIN_I.valid
        |=> REG_RVALID_O && REG_RDATA_O == {10'h000, count})
        else $error("count register read wrong");

    chk_start_reset: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        $rose(ARST_N_I) |-> slave_id_start_q == SLAVE_ID_START_RST)
        else $error("starting slave id not at reset value");

    chk_forced_readback: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        wr_forced ##1 !wr_forced
            ##1 (REG_REQ_I.rd && sel_forced && !REG_REQ_I.wr)
        |=> REG_RDATA_O == $past(REG_REQ_I.wdata, 3))
        else $error("forced parent readback mismatch");

    chk_removal_search: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        removal |=> PATH_SEARCH_O && !FORCED_ACTIVE_O ##1 !PATH_SEARCH_O || removal)
        else $error("removal did not pulse path search");

    chk_bound_kept: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        wr_forced && BOUND_I ##1 BOUND_I |=> BOUND_O)
        else $error("binding lost on forced parent write");

    chk_bound_follow: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        $past(ARST_N_I) |-> BOUND_O == $past(BOUND_I))
        else $error("bound copy does not follow radio");

    chk_map_range: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        MAP_REQ_I && (MAP_SLAVE_ID_I < slave_id_start_q
            || MAP_SLAVE_ID_I - slave_id_start_q >= 16'h0032) |=> MAP_VALID_O && !MAP_HIT_O)
        else $error("out of range slave id mapped");

    chk_map_direct: assert property (
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        MAP_HIT_O |-> MAP_DIRECT_O == (MAP_ENTRY_O.first_hop_address == MAP_ENTRY_O.dev_addr))
        else $error("direct link flag wrong");

endmodule

// ==== testbench/modbus_host_model.sv ====
// Host model: issues holding-register reads and writes to the formation table.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/10ps
module modbus_host_model (
    // Clock
    input wire logic core_clk_i,
    // Register port
    output nft_pkg::reg_req_t req_o,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i
);
    import nft_pkg::*;

    // Idle bus shows the inverse of the last request, never stale data
    initial req_o = '{rd: 1'b0, wr: 1'b0, addr: 16'hffff, wdata: 16'hffff};

    ////////////////////////////////////////////////////////////////////////////
    // Parent values written are 1..65535, or zero to remove forcing
    task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
        @(posedge core_clk_i);
        req_o <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge core_clk_i);
        req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
        #1;
    endtask

    task automatic read_reg(input logic [15:0] addr, output logic [15:0] data,
                            output logic ok);
        @(posedge core_clk_i);
        req_o <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 16'h0000};
        @(posedge core_clk_i);
        req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 16'hffff};
        // Answer is registered, so it lands just after the taking edge
        #1;
        ok = rvalid_i;
        data = rdata_i;
    endtask
endmodule

// ==== testbench/test_network_formation_table.sv ====
// Self-checking bench for the network formation table register bank.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/10ps
module test_network_formation_table;
    import nft_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] serial = 32'h5a5ab1c4;
    logic repeater = 1'b0;
    logic bound = 1'b1;
    join_t join_r = '0;
    logic mreq = 1'b0;
    logic [15:0] mid = 16'h0000;
    reg_req_t req;
    logic [15:0] rdata, fparent, devaddr, rd;
    logic rvalid, mvalid, mhit, mdirect, mall, mfew, factive, psearch, bound_o, ok;
    entry_t mentry;
    entry_t ent [4];
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    initial forever #12.5 core_clk = ~core_clk;

    network_formation_table dut_u (
        .CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .SERIAL_I(serial),
        .ROLE_REPEATER_I(repeater), .BOUND_I(bound), .JOIN_I(join_r),
        .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .MAP_REQ_I(mreq), .MAP_SLAVE_ID_I(mid), .MAP_VALID_O(mvalid),
        .MAP_HIT_O(mhit), .MAP_ENTRY_O(mentry), .MAP_DIRECT_O(mdirect),
        .MAP_SLOTS_ALL_O(mall), .MAP_SLOTS_FEW_O(mfew), .DEVICE_ADDR_O(devaddr),
        .FORCED_PARENT_O(fparent), .FORCED_ACTIVE_O(factive),
        .PATH_SEARCH_O(psearch), .BOUND_O(bound_o)
    );

    modbus_host_model host_u (
        .core_clk_i(core_clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("Summary: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            $display("Error at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
        host_u.read_reg(addr, rd, ok);
        check({ok, rd}, {1'b1, exp}, $sformatf("read of %h", addr));
    endtask

    task automatic map_chk(input logic [15:0] id, input logic hit, input entry_t e,
                           input logic [2:0] fl);
        @(posedge core_clk);
        mreq <= 1'b1;
        mid <= id;
        @(posedge core_clk);
        mreq <= 1'b0;
        mid <= ~id;
        #1;
        check({mvalid, mhit, mdirect, mall, mfew}, {1'b1, hit, fl}, "map flags");
        check(mentry, e, "map entry");
    endtask

    task automatic send_join(input entry_t e);
        @(posedge core_clk);
        join_r <= '{valid: 1'b1, entry: e};
    endtask

    task automatic join_idle();
        @(posedge core_clk);
        join_r <= '0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check(devaddr, serial[15:0], "own address");
        check(bound_o, 1'b1, "bound copy");
        rd_chk(REG_SLAVE_ID_START, SLAVE_ID_START_RST);
        rd_chk(REG_FORCED_PARENT, FORCED_PARENT_RST);
        rd_chk(REG_ADDRESS_COUNT, 16'h0000);
        rd_chk(REG_DEVICE_ADDRESSES, 16'h0000);
        $display("Test reset done");
    endtask

    task automatic t_join();
        foreach (ent[i]) send_join(ent[i]);
        join_idle();
        rd_chk(REG_ADDRESS_COUNT, 16'h0004);
        rd_chk(REG_ROUTE_COUNT, 16'h0004);
        rd_chk(REG_SLOT_COUNT, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            rd_chk(REG_DEVICE_ADDRESSES + i[15:0], ent[i].dev_addr);
            rd_chk(REG_ROUTE_ADDRESSES + i[15:0], ent[i].first_hop_address);
            rd_chk(REG_SLOT_AVAILABILITY + i[15:0], ent[i].slot_availability);
        end
        rd_chk(REG_DEVICE_ADDRESSES + 16'h0004, 16'h0000);
        // Re-report of a known device updates in place
        ent[1].slot_availability = SLOTS_FEW;
        send_join(ent[1]);
        join_idle();
        rd_chk(REG_ADDRESS_COUNT, 16'h0004);
        rd_chk(REG_SLOT_AVAILABILITY + 16'h0001, SLOTS_FEW);
        $display("Test join done");
    endtask

    task automatic t_map();
        map_chk(16'h000b, 1'b1, ent[0], 3'b110);
        map_chk(16'h000c, 1'b1, ent[1], 3'b001);
        map_chk(16'h000e, 1'b1, ent[3], 3'b100);
        map_chk(16'h000a, 1'b0, '0, 3'b000);
        map_chk(16'h000f, 1'b0, '0, 3'b000);
        for (int i = 0; i < 4; i++) begin
            rd_chk(REG_SLAVE_ID_LIST + i[15:0], ent[i].dev_addr);
        end
        host_u.write_reg(REG_SLAVE_ID_START, 16'h0014);
        map_chk(16'h0014, 1'b1, ent[0], 3'b110);
        map_chk(16'h000b, 1'b0, '0, 3'b000);
        host_u.write_reg(REG_SLAVE_ID_START, SLAVE_ID_START_RST);
        rd_chk(REG_SLAVE_ID_START, SLAVE_ID_START_RST);
        $display("Test map done");
    endtask

    task automatic t_force();
        host_u.write_reg(REG_FORCED_PARENT, 16'hffff);
        check({fparent, factive, psearch}, {16'hffff, 2'b10}, "force max");
        rd_chk(REG_FORCED_PARENT, 16'hffff);
        host_u.write_reg(REG_FORCED_PARENT, 16'h0001);
        check({fparent, factive, psearch}, {16'h0001, 2'b10}, "force min");
        host_u.write_reg(REG_FORCED_PARENT, FORCED_PARENT_NONE);
        check({fparent, factive, psearch, bound_o}, {16'h0000, 3'b011}, "remove");
        @(posedge core_clk);
        #1;
        check(psearch, 1'b0, "search pulse width");
        host_u.write_reg(REG_FORCED_PARENT, FORCED_PARENT_NONE);
        check({psearch, bound_o}, 2'b01, "no search when idle");
        // Forcing must neither need nor restore binding
        @(posedge core_clk);
        bound <= 1'b0;
        host_u.write_reg(REG_FORCED_PARENT, 16'h0002);
        check({factive, bound_o}, 2'b10, "force while unbound");
        @(posedge core_clk);
        bound <= 1'b1;
        host_u.write_reg(REG_ADDRESS_COUNT, 16'h0007);
        rd_chk(REG_ADDRESS_COUNT, 16'h0004);
        $display("Test force done");
    endtask

    task automatic t_repeater();
        @(posedge core_clk);
        repeater <= 1'b1;
        rd_chk(REG_SLAVE_ID_LIST, 16'h0000);
        map_chk(16'h000b, 1'b0, '0, 3'b000);
        rd_chk(REG_ROUTE_ADDRESSES + 16'h0002, ent[2].first_hop_address);
        @(posedge core_clk);
        repeater <= 1'b0;
        $display("Test repeater done");
    endtask

    task automatic t_full();
        for (int i = 0; i < 46; i++) begin
            send_join('{16'h1000 + i[15:0], 16'h1000 + i[15:0], SLOTS_FEW});
        end
        // One more while full is dropped
        send_join('{16'h2000, 16'h2000, SLOTS_ALL});
        join_idle();
        rd_chk(REG_ADDRESS_COUNT, {10'h000, TABLE_DEPTH_C});
        rd_chk(REG_DEVICE_ADDRESSES + 16'h0031, 16'h102d);
        rd_chk(REG_SLOT_AVAILABILITY + 16'h0031, SLOTS_FEW);
        rd_chk(REG_DEVICE_ADDRESSES + 16'h0032, 16'h0000);
        rd_chk(REG_SLAVE_ID_LIST + 16'h0031, 16'h102d);
        map_chk(16'h003c, 1'b1, '{16'h102d, 16'h102d, SLOTS_FEW}, 3'b101);
        map_chk(16'h003d, 1'b0, '0, 3'b000);
        $display("Test full done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ent[0] = '{16'ha8cb, 16'ha8cb, SLOTS_ALL};
        ent[1] = '{16'hadd4, 16'hb42b, 16'h0020};
        ent[2] = '{16'hb86f, 16'hb42b, 16'h0020};
        ent[3] = '{16'hb42b, 16'hb42b, 16'h0020};
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        t_reset();
        t_join();
        t_map();
        t_force();
        t_repeater();
        t_full();
        results();
    end
endmodule
